// File: mdps_pkg.sv
// Package for the multi-channel UART and supply switching matrix.
// Assumes a single 20 MHz board clock and a plain strobe register port.
package mdps_pkg;

  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned CAL_PULSE_MS   = 500;
  localparam int unsigned CAL_PULSE_CYC  = (CLK_HZ / 1000) * CAL_PULSE_MS;
  localparam int unsigned NUM_CH         = 16;

  // Register indices on the command port.
  localparam logic [3:0] ADDR_ROUTE_MODE = 4'h0;
  localparam logic [3:0] ADDR_BAT_EN     = 4'h1;
  localparam logic [3:0] ADDR_PROG_EN    = 4'h2;
  localparam logic [3:0] ADDR_UART_EN    = 4'h3;
  localparam logic [3:0] ADDR_CONTROL    = 4'h4;
  localparam logic [3:0] ADDR_STATUS     = 4'h5;
  localparam logic [3:0] ADDR_HDR_SEL    = 4'h6;
  localparam logic [3:0] ADDR_ROUTE_HI   = 4'h7;

  // Control and status register field positions.
  localparam int unsigned CTL_DUT_RESET  = 0;
  localparam int unsigned CTL_BAT_AS_RST = 1;
  localparam int unsigned CTL_CAL_START  = 2;
  localparam int unsigned STS_CAL_BUSY   = 0;
  localparam int unsigned STS_CAL_LEVEL  = 1;

  // Routing mode encodings, two bits per channel.
  localparam logic [1:0] MODE_NORMAL     = 2'h0;
  localparam logic [1:0] MODE_XTAL_TRIM  = 2'h1;
  localparam logic [1:0] MODE_LOOPBACK   = 2'h2;

  localparam logic [31:0] REG_RESET      = 32'h0000_0000;

endpackage

// File: mdps_cal_timer.sv
// Calibration pulse timer: one start strobe yields one high pulse of fixed length.
// Assumes the start strobe comes from logic on the same clock.
`timescale 1ns/10ps
module mdps_cal_timer
  import mdps_pkg::*;
#(
  parameter int unsigned PULSE_CYC = CAL_PULSE_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_start,
  output logic      o_pulse
);

  logic [31:0] count;

  // Restarting while busy is ignored so a pulse is never cut short.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count   <= 32'h0000_0000;
      o_pulse <= 1'b0;
    end else if (o_pulse) begin
      if (count == 32'(PULSE_CYC - 1)) begin
        o_pulse <= 1'b0;
        count   <= 32'h0000_0000;
      end else begin
        count <= count + 32'h0000_0001;
      end
    end else if (i_start) begin
      o_pulse <= 1'b1;
      count   <= 32'h0000_0000;
    end
  end

endmodule

// File: mdps_switch_matrix.sv
// Sixteen-channel UART routing and DUT supply switching matrix.
// Assumes UART pins from bridges and DUTs are asynchronous and are synchronised here;
// the command port is driven by logic on i_clk.
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/10ps

// Summary of operation
// - Sixteen channels, each pairing one host bridge port with one DUT.
// - Per channel, UART transmit and receive lines connect or disconnect on command.
// - Per channel, battery supply to the DUT switches on or off on command.
// - Programming supply is on only while that channel's battery supply is on.
// - A DUT reset output is driven whenever commanded.
// - An internal timer makes a 500 ms calibration pulse from the board clock.
// - Normal mode passes host data to DUT receive and DUT data back to host.
// - Trim mode feeds DUT receive from the pulse timer; DUT transmit still returns.
// - Loopback mode returns host transmit data straight to its receive line.
// - Outside loopback mode, battery off forces the channel's UART signals disconnected, unless the battery line acts as reset.
// - Supply/reset mode makes the battery line act as supply or as reset.
// - With the battery line as reset, programming supply switching is withheld.
// - Calibration pulse goes on DUT receive, or on a header pin instead.
// - Supplies are switched off one channel at a time by rewriting the battery enables.
module mdps_switch_matrix
  import mdps_pkg::*;
#(
  parameter int unsigned N_CH      = NUM_CH,
  parameter int unsigned PULSE_CYC = CAL_PULSE_CYC
) (
  input  wire logic            i_clk,
  input  wire logic            i_rst,
  input  wire logic [3:0]      i_addr,
  input  wire logic [31:0]     i_wdata,
  input  wire logic            i_wr,
  input  wire logic            i_rd,
  output logic      [31:0]     o_rdata,
  input  wire logic [N_CH-1:0] i_host_tx,
  output logic      [N_CH-1:0] o_host_rx,
  input  wire logic [N_CH-1:0] i_dut_tx,
  output logic      [N_CH-1:0] o_dut_rx,
  output logic      [N_CH-1:0] o_dut_bat,
  output logic      [N_CH-1:0] o_dut_prog,
  output logic      [N_CH-1:0] o_dut_reset,
  output logic      [N_CH-1:0] o_cal_header
);

  // Command registers, written only through the command port. Register map by index:
  // 0 routing modes, two bits per channel: 0 normal, 1 crystal trim, 2 loopback, 3 idle.
  // 1 battery supply enable, 2 programming supply enable, 3 UART connect enable.
  // 4 control: bit 0 DUT reset, bit 1 battery line as reset, bit 2 timer start.
  // 5 status, read only: bit 0 timer busy, bit 1 pulse level.
  // 6 header select: the pulse leaves on the header pin instead of DUT receive.
  // 7 spare at sixteen channels: it reads zero and ignores writes.
  logic [2*N_CH-1:0] route_mode;
  logic [N_CH-1:0]   bat_en;
  logic [N_CH-1:0]   prog_en;
  logic [N_CH-1:0]   uart_en;
  logic [N_CH-1:0]   hdr_sel;
  logic              dut_reset;
  logic              bat_as_rst;
  logic              cal_start;
  logic              cal_pulse;

  // Write strobes decoded per register, and the per-channel live flag.
  logic              wr_route;
  logic              wr_bat;
  logic              wr_prog;
  logic              wr_uart;
  logic              wr_hdr;
  logic              wr_ctl;
  logic [N_CH-1:0]   live;

  // Two-stage synchronisers for the asynchronous UART inputs.
  logic [N_CH-1:0]   host_tx_m;
  logic [N_CH-1:0]   host_tx_s;
  logic [N_CH-1:0]   dut_tx_m;
  logic [N_CH-1:0]   dut_tx_s;

  // Next values of the routed outputs.
  logic [N_CH-1:0]   next_host_rx;
  logic [N_CH-1:0]   next_dut_rx;
  logic [N_CH-1:0]   next_dut_bat;
  logic [N_CH-1:0]   next_dut_prog;
  logic [N_CH-1:0]   next_dut_reset;
  logic [N_CH-1:0]   next_cal_header;

  // Returns the two-bit routing mode of one channel.
  function automatic logic [1:0] mode_of(input logic [2*N_CH-1:0] modes,
                                         input int unsigned ch);
    mode_of = modes[2*ch +: 2];
  endfunction

  // Widens a channel vector to a read word, upper bits reading zero.
  function automatic logic [31:0] widen(input logic [N_CH-1:0] v);
    widen = 32'h0000_0000;
    widen[N_CH-1:0] = v;
  endfunction

  // Host transmit synchroniser: the first stage feeds only the second.
  // Idle high in reset, so no false start bit reaches a DUT after reset.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      host_tx_m <= '1;
      host_tx_s <= '1;
    end else begin
      host_tx_m <= i_host_tx;
      host_tx_s <= host_tx_m;
    end
  end

  // DUT transmit synchroniser, built the same way.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dut_tx_m <= '1;
      dut_tx_s <= '1;
    end else begin
      dut_tx_m <= i_dut_tx;
      dut_tx_s <= dut_tx_m;
    end
  end

  // Write decode; the switches change only on these relayed commands.
  always_comb begin
    wr_route = i_wr && (i_addr == ADDR_ROUTE_MODE);
    wr_bat   = i_wr && (i_addr == ADDR_BAT_EN);
    wr_prog  = i_wr && (i_addr == ADDR_PROG_EN);
    wr_uart  = i_wr && (i_addr == ADDR_UART_EN);
    wr_hdr   = i_wr && (i_addr == ADDR_HDR_SEL);
    wr_ctl   = i_wr && (i_addr == ADDR_CONTROL);
  end

  // Routing modes. The spare index holds no bits, so a write there changes nothing.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      route_mode <= '0;
    end else if (wr_route) begin
      route_mode <= i_wdata[2*N_CH-1:0];
    end
  end

  // Battery enables. Supplies are dropped channel by channel by rewriting this mask.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bat_en <= '0;
    end else if (wr_bat) begin
      bat_en <= i_wdata[N_CH-1:0];
    end
  end

  // Programming supply enables; the output stage applies the battery interlock.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prog_en <= '0;
    end else if (wr_prog) begin
      prog_en <= i_wdata[N_CH-1:0];
    end
  end

  // UART connect enables.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      uart_en <= '0;
    end else if (wr_uart) begin
      uart_en <= i_wdata[N_CH-1:0];
    end
  end

  // Header select for the calibration pulse, for DUTs whose receive pin is taken.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hdr_sel <= '0;
    end else if (wr_hdr) begin
      hdr_sel <= i_wdata[N_CH-1:0];
    end
  end

  // Control bits; the timer start bit is not stored here.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dut_reset  <= 1'b0;
      bat_as_rst <= 1'b0;
    end else if (wr_ctl) begin
      dut_reset  <= i_wdata[CTL_DUT_RESET];
      bat_as_rst <= i_wdata[CTL_BAT_AS_RST];
    end
  end

  // The start bit is self-clearing, so it acts as a one-cycle strobe.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cal_start <= 1'b0;
    end else begin
      cal_start <= wr_ctl && i_wdata[CTL_CAL_START];
    end
  end

  // The calibration pulse timer.
  mdps_cal_timer #(
    .PULSE_CYC (PULSE_CYC)
  ) u_calibration_pulse_timer (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_start (cal_start),
    .o_pulse (cal_pulse)
  );

  // A channel is live while connected and its DUT is powered or held by the reset line.
  always_comb begin
    live = uart_en & (bat_en | {N_CH{bat_as_rst}});
  end

  // Per-channel routing and supply gating.
  // When disconnected outside loopback mode, host receive idles high and DUT receive is held low, which a powered-off DUT sees as no drive.
  always_comb begin
    for (int unsigned ch = 0; ch < N_CH; ch++) begin
      logic [1:0] md;
      md   = mode_of(route_mode, ch);
      next_host_rx[ch]    = 1'b1;
      next_dut_rx[ch]     = 1'b0;
      next_cal_header[ch] = 1'b0;
      case (md)
        MODE_NORMAL: begin
          if (live[ch]) begin
            next_dut_rx[ch]  = host_tx_s[ch];
            next_host_rx[ch] = dut_tx_s[ch];
          end
        end
        MODE_XTAL_TRIM: begin
          if (live[ch]) begin
            next_host_rx[ch] = dut_tx_s[ch];
            if (hdr_sel[ch]) begin
              next_cal_header[ch] = cal_pulse;
              next_dut_rx[ch]     = 1'b1;
            end else begin
              next_dut_rx[ch] = cal_pulse;
            end
          end
        end
        MODE_LOOPBACK: begin
          next_host_rx[ch] = host_tx_s[ch];
        end
        default: begin
          next_host_rx[ch] = 1'b1;
        end
      endcase
    end
  end

  // Battery line as supply or as reset, and programming supply interlock.
  always_comb begin
    if (bat_as_rst) begin
      next_dut_bat  = dut_reset ? '0 : bat_en;
      next_dut_prog = '0;
    end else begin
      next_dut_bat  = bat_en;
      next_dut_prog = prog_en & bat_en;
    end
    next_dut_reset = dut_reset ? '1 : '0;
  end

  // Registered UART outputs; a released host receive line idles high.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_host_rx    <= '1;
      o_dut_rx     <= '0;
      o_cal_header <= '0;
    end else begin
      o_host_rx    <= next_host_rx;
      o_dut_rx     <= next_dut_rx;
      o_cal_header <= next_cal_header;
    end
  end

  // Registered supply and reset outputs, so the switch gates see no decode glitches.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_dut_bat   <= '0;
      o_dut_prog  <= '0;
      o_dut_reset <= '0;
    end else begin
      o_dut_bat   <= next_dut_bat;
      o_dut_prog  <= next_dut_prog;
      o_dut_reset <= next_dut_reset;
    end
  end

  // Read port: data stands in the cycle after the strobe, zero otherwise.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= REG_RESET;
    end else if (i_rd) begin
      case (i_addr)
        ADDR_ROUTE_MODE: o_rdata <= route_mode[31:0];
        ADDR_BAT_EN:     o_rdata <= widen(bat_en);
        ADDR_PROG_EN:    o_rdata <= widen(prog_en);
        ADDR_UART_EN:    o_rdata <= widen(uart_en);
        ADDR_HDR_SEL:    o_rdata <= widen(hdr_sel);
        ADDR_CONTROL:    o_rdata <= {30'h0, bat_as_rst, dut_reset};
        ADDR_STATUS:     o_rdata <= {30'h0, cal_pulse, cal_pulse};
        default:         o_rdata <= REG_RESET;
      endcase
    end else begin
      o_rdata <= REG_RESET;
    end
  end

endmodule

// File: mdps_chk_sva.sv
// Checker for the switching matrix, watching only the top-level ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module mdps_chk
  import mdps_pkg::*;
#(
  parameter int unsigned PULSE_CYC = 20
) (
  input logic        i_clk,
  input logic        i_rst,
  input logic [3:0]  i_addr,
  input logic [31:0] i_wdata,
  input logic        i_wr,
  input logic        i_rd,
  input logic [31:0] o_rdata,
  input logic [15:0] i_host_tx,
  input logic [15:0] o_host_rx,
  input logic [15:0] i_dut_tx,
  input logic [15:0] o_dut_rx,
  input logic [15:0] o_dut_bat,
  input logic [15:0] o_dut_prog,
  input logic [15:0] o_dut_reset,
  input logic [15:0] o_cal_header
);
  logic [31:0] shd [8];
  int unsigned quiet;
  int unsigned hi;
  logic        live;
  logic [1:0]  m0;
  // Shadow each word written to indices 0 to 6; quiet counts cycles since the last write.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      shd   <= '{default: '0};
      quiet <= 0;
    end else begin
      quiet <= i_wr ? 0 : quiet + 1;
      if (i_wr && i_addr < 4'h7) shd[i_addr[2:0]] <= i_wdata;
    end
  end
  // Width of the current header pulse, so its length can be judged at the fall.
  always_ff @(posedge i_clk) hi <= o_cal_header[0] ? hi + 1 : 0;
  // Channel 0 only: the others share the same logic.
  assign live = shd[3][0] & (shd[1][0] | shd[4][1]);
  assign m0   = shd[0][1:0];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  idle_rdata_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its slot");
  reset_state_a: assert property ($fell(i_rst) |-> o_host_rx == 16'hFFFF && o_dut_bat == 16'h0)
    else $error("outputs not at reset state");
  bat_follow_a: assert property (quiet > 2 |-> o_dut_bat == (shd[4][1] && shd[4][0] ? 16'h0 : shd[1][15:0]))
    else $error("battery output wrong");
  prog_gate_a: assert property (quiet > 2 |-> o_dut_prog == (shd[4][1] ? 16'h0 : shd[2][15:0] & shd[1][15:0]))
    else $error("programming supply wrong");
  dut_reset_a: assert property (quiet > 2 |-> o_dut_reset == {16{shd[4][0]}})
    else $error("reset output wrong");
  normal_path_a: assert property (quiet > 3 && m0 == MODE_NORMAL && live && !shd[6][0]
    |-> o_dut_rx[0] == $past(i_host_tx[0], 3) && o_host_rx[0] == $past(i_dut_tx[0], 3))
    else $error("normal routing wrong");
  trim_return_a: assert property (quiet > 3 && m0 == MODE_XTAL_TRIM && live
    |-> o_host_rx[0] == $past(i_dut_tx[0], 3))
    else $error("trim return path wrong");
  loop_path_a: assert property (quiet > 3 && m0 == MODE_LOOPBACK
    |-> o_host_rx[0] == $past(i_host_tx[0], 3))
    else $error("loopback path wrong");
  dead_chan_a: assert property (quiet > 3 && !live && m0 != MODE_LOOPBACK && !shd[6][0]
    |-> o_host_rx[0] && !o_dut_rx[0])
    else $error("unpowered channel not isolated");
  pulse_len_a: assert property ($fell(o_cal_header[0]) |-> hi == PULSE_CYC)
    else $error("calibration pulse length wrong");
endmodule

bind mdps_switch_matrix mdps_chk #(.PULSE_CYC(PULSE_CYC)) i_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_host_tx(i_host_tx), .o_host_rx(o_host_rx), .i_dut_tx(i_dut_tx), .o_dut_rx(o_dut_rx),
  .o_dut_bat(o_dut_bat), .o_dut_prog(o_dut_prog), .o_dut_reset(o_dut_reset),
  .o_cal_header(o_cal_header));

// File: mdps_far_end.sv
// Far-side model: bridge and DUT transmit lines as level sources.
// Assumes the bench hands it a fresh bit pattern every clock.
`timescale 1ns/10ps
module mdps_far_end (
  input  logic        i_clk,
  input  logic        i_run,
  input  logic [31:0] i_pat,
  output logic [15:0] o_host_tx,
  output logic [15:0] o_dut_tx
);
  // Lines hold their level while paused, so the bench can compare settled paths.
  always @(posedge i_clk) begin
    if (i_run) begin
      o_host_tx <= i_pat[15:0];
      o_dut_tx  <= i_pat[31:16];
    end
  end
endmodule

// File: tb.sv
// Top bench: drives the command port, models the matrix and compares.
// Assumes the package, design, checker and far-side model compile first.
`timescale 1ns/10ps
module tb;
  import mdps_pkg::*;
  localparam int PC = 20;
  logic        i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, run = 1;
  logic [3:0]  i_addr = 0;
  logic [31:0] i_wdata = 0, o_rdata, pat = 0;
  logic [15:0] htx, hrx, dtx, drx, bat, prog, drst, hdr;
  int          err_count = 0, total_checks = 0, seed = 52, n, m [8];
  always #25 i_clk = ~i_clk;
  // Random traffic for the far side.
  always @(posedge i_clk) pat <= $random(seed);
  mdps_far_end i_mdps_far_end (.i_clk(i_clk), .i_run(run), .i_pat(pat), .o_host_tx(htx),
    .o_dut_tx(dtx));
  mdps_switch_matrix #(.PULSE_CYC(PC)) i_mdps_switch_matrix (.i_clk(i_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_host_tx(htx), .o_host_rx(hrx), .i_dut_tx(dtx), .o_dut_rx(drx), .o_dut_bat(bat),
    .o_dut_prog(prog), .o_dut_reset(drst), .o_cal_header(hdr));
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  // A gap cycle follows each strobe, so no task reassigns it in one step.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 0;
    if (a < 7) m[a] = d;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_rd   <= 1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 0;
    @(negedge i_clk);
    chk("rdata", e, o_rdata);
  endtask
  // Compares every channel with the model once paths have settled.
  task automatic cmp;
    logic [15:0] eh, ed;
    int md, lv;
    repeat (6) @(posedge i_clk);
    @(negedge i_clk);
    for (int c = 0; c < 16; c++) begin
      md    = (m[0] >> 2 * c) & 3;
      lv    = m[3][c] & (m[1][c] | m[4][1]);
      eh[c] = md == 2 ? htx[c] : (lv && md < 2) ? dtx[c] : 1'b1;
      ed[c] = !lv ? 1'b0 : md == 0 ? htx[c] : md == 1 ? m[6][c] : 1'b0;
    end
    chk("host_rx", eh, hrx);
    chk("dut_rx", ed, drx);
    chk("bat", m[4][1] && m[4][0] ? 0 : m[1][15:0], bat);
    chk("prog", m[4][1] ? 0 : m[1][15:0] & m[2][15:0], prog);
    chk("reset", {16{m[4][0]}}, drst);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 0;
    run   <= 0;
    cmp;
    wr(4'h9, 32'hFFFF_FFFF);
    rd(4'h9, 0);
    rd(4'h7, 0);
    for (int k = 0; k < 24; k++) begin
      run <= 1;
      wr(ADDR_ROUTE_MODE, $random(seed));
      wr(ADDR_BAT_EN, $random(seed));
      wr(ADDR_PROG_EN, $random(seed));
      wr(ADDR_UART_EN, $random(seed));
      wr(ADDR_HDR_SEL, $random(seed));
      wr(ADDR_CONTROL, $random(seed) & 3);
      rd(ADDR_ROUTE_MODE, m[0]);
      rd(ADDR_CONTROL, m[4] & 3);
      repeat (8) @(posedge i_clk);
      run <= 0;
      cmp;
    end
    wr(ADDR_CONTROL, 0);
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_BAT_EN, 32'hFFFF << c);
      cmp;
    end
    // Reset in mid-run: every channel must fall back to its power-on state.
    @(posedge i_clk);
    i_rst <= 1;
    repeat (2) @(posedge i_clk);
    i_rst <= 0;
    m = '{default: 0};
    cmp;
    wr(ADDR_UART_EN, 3);
    wr(ADDR_BAT_EN, 3);
    wr(ADDR_ROUTE_MODE, 5);
    wr(ADDR_HDR_SEL, 1);
    wr(ADDR_CONTROL, 4);
    fork
      begin
        n = 0;
        while (drx[1] !== 1'b1 && n < 50) begin
          @(negedge i_clk);
          n++;
        end
        chk("cal_routes", 32'h0001_0003, {hdr, drx});
        n = 0;
        while (drx[1] === 1'b1 && n < 100) begin
          @(negedge i_clk);
          n++;
        end
        chk("pulse_len", PC, n);
      end
      begin
        repeat (6) @(posedge i_clk);
        wr(ADDR_CONTROL, 4);
        rd(ADDR_STATUS, 3);
      end
    join
    rd(ADDR_STATUS, 0);
    give_verdict;
  end
  // Watchdog well beyond the expected run length.
  initial begin
    #200_000;
    err_count++;
    give_verdict;
  end
endmodule
